/* logic/frp_device.sv */
`timescale 1ns/100ps
`include "frp_map.svh"
module frp_device
  import frp_pkg::*;
(
  // Clock and reset
  input wire logic mclk,
  input wire logic reset,
  // Flash pins
  frp_if.dev bus,
  // Status
  output logic sleeping,
  output logic corrupt_flag,
  output logic [15:0] config_reg
);
  // ---------------------------------------------
  // Storage
  // ---------------------------------------------
  logic [15:0] mem_q [0:15];
  logic [15:0] mark_rom [0:`FRP_MARK_WORDS-1];
  assign mark_rom[0] = 16'h1234; // Arbitrary marking value
  assign mark_rom[1] = 16'h5678;
  assign mark_rom[2] = 16'h9ABC;
  assign mark_rom[3] = 16'hDEF0;

  frp_state_type st_q, st_d;
  logic [15:0] cnt_q, cnt_d;
  logic [15:0] idle_q, idle_d;
  logic [15:0] cfg_q, cfg_d;
  logic [15:0] dout_q, dout_d;
  logic doe_q, doe_d;
  logic rb_q, rb_d;
  logic sleep_q, sleep_d;
  logic bad_q, bad_d;
  logic [3:0] tgt_q, tgt_d;
  logic [15:0] pdat_q, pdat_d;
  logic [15:0] last_addr_q, last_addr_d;
  logic we_n_q, we_n_d;
  logic wr_edge;

  function automatic logic is_mark(input logic [15:0] a);
    is_mark = (a[15:4] == 12'hFFF);
  endfunction : is_mark

  assign wr_edge = !we_n_q && bus.we_n && !bus.ce_n && bus.oe_n;

  // ---------------------------------------------
  // Next state
  // ---------------------------------------------
  always_comb
  begin
    st_d = st_q;
    cnt_d = cnt_q;
    idle_d = idle_q;
    cfg_d = cfg_q;
    dout_d = dout_q;
    doe_d = doe_q;
    rb_d = rb_q;
    sleep_d = sleep_q;
    bad_d = bad_q;
    tgt_d = tgt_q;
    pdat_d = pdat_q;
    last_addr_d = bus.addr;
    we_n_d = bus.we_n;
    if (!bus.reset_n)
    begin
      // Abort, float, clear config, ignore all cycles
      doe_d = 1'b0;
      cfg_d = `FRP_CFG_RESET;
      sleep_d = 1'b0;
      if (st_q == ST_BUSY)
      begin
        st_d = ST_RST_BUSY;
        cnt_d = 16'(`FRP_RST_BUSY_CYC);
        bad_d = 1'b1;
        rb_d = 1'b0;
      end
      else if (st_q == ST_READ)
      begin
        st_d = ST_RST_IDLE;
        cnt_d = 16'(`FRP_RST_IDLE_CYC);
      end
    end
    else
    begin
      case (st_q)
        ST_READ:
        begin
          rb_d = 1'b1;
          if (wr_edge)
          begin
            if (bus.addr[15:12] == 4'hC)
              cfg_d = bus.dq_host;
            else if (!is_mark(bus.addr))
            begin
              st_d = ST_BUSY;
              cnt_d = 16'(`FRP_OP_CYC);
              tgt_d = bus.addr[3:0];
              pdat_d = bus.dq_host;
              rb_d = 1'b0;
            end
          end
        end
        ST_BUSY:
        begin
          // Deselect does not stop the operation
          if (cnt_q == 16'h0000)
          begin
            st_d = ST_READ;
            rb_d = 1'b1;
            bad_d = 1'b0;
          end
          else
            cnt_d = cnt_q - 16'h0001;
        end
        ST_RST_BUSY, ST_RST_IDLE:
        begin
          if (cnt_q == 16'h0000)
          begin
            st_d = ST_READ;
            rb_d = 1'b1;
          end
          else
            cnt_d = cnt_q - 16'h0001;
        end
        default: st_d = ST_READ;
      endcase
      // Output path only while reading
      if (st_d == ST_READ || st_q == ST_READ)
      begin
        if (bus.ce_n || bus.oe_n)
        begin
          doe_d = 1'b0;
          sleep_d = 1'b0;
        end
        else
        begin
          doe_d = 1'b1;
          // New burst start restarts access like an address change
          if (bus.addr != last_addr_q || !bus.burst_n)
          begin
            idle_d = 16'h0000;
            sleep_d = 1'b0;
          end
          else if (idle_q < 16'(`FRP_SLEEP_CYC))
            idle_d = idle_q + 16'h0001;
          else
            sleep_d = 1'b1;
          // Sleep latches data; new address brings new data
          if (!sleep_q || bus.addr != last_addr_q)
            dout_d = is_mark(bus.addr) ? mark_rom[bus.addr[1:0]]
                                       : mem_q[bus.addr[3:0]];
        end
      end
      else
        doe_d = 1'b0;
    end
  end

  // ---------------------------------------------
  // Registers
  // ---------------------------------------------
  always_ff @(posedge mclk)
  begin
    if (reset)
    begin
      st_q <= ST_READ;
      cnt_q <= 16'h0000;
      idle_q <= 16'h0000;
      cfg_q <= `FRP_CFG_RESET;
      dout_q <= 16'h0000;
      doe_q <= 1'b0;
      rb_q <= 1'b1;
      sleep_q <= 1'b0;
      bad_q <= 1'b0;
      tgt_q <= 4'h0;
      pdat_q <= 16'h0000;
      last_addr_q <= 16'h0000;
      we_n_q <= 1'b1;
    end
    else
    begin
      st_q <= st_d;
      cnt_q <= cnt_d;
      idle_q <= idle_d;
      cfg_q <= cfg_d;
      dout_q <= dout_d;
      doe_q <= doe_d;
      rb_q <= rb_d;
      sleep_q <= sleep_d;
      bad_q <= bad_d;
      tgt_q <= tgt_d;
      pdat_q <= pdat_d;
      last_addr_q <= last_addr_d;
      we_n_q <= we_n_d;
    end
  end

  // ---------------------------------------------
  // Array
  // ---------------------------------------------
  always_ff @(posedge mclk)
  begin
    if (st_q == ST_BUSY && cnt_q == 16'h0000 && bus.reset_n)
      mem_q[tgt_q] <= pdat_q;
    else if (st_q == ST_BUSY && !bus.reset_n)
      mem_q[tgt_q] <= 16'hDEAD;
  end

  assign bus.dq_dev = dout_q;
  assign bus.dq_dev_oe = doe_q;
  assign bus.ready_busy_n = rb_q;
  assign sleeping = sleep_q;
  assign corrupt_flag = bad_q;
  assign config_reg = cfg_q;
endmodule : frp_device

/* logic/frp_host.sv */
`timescale 1ns/100ps
`include "frp_map.svh"
module frp_host
  import frp_pkg::*;
(
  // Clock and reset
  input wire logic mclk,
  input wire logic reset,
  // Flash pins
  frp_if.host bus,
  // User side
  input wire logic req,
  input wire frp_cmd_type cmd,
  input wire logic [15:0] req_addr,
  input wire logic [15:0] req_data,
  input wire logic do_reset,
  output logic done,
  output logic [15:0] rd_data,
  output logic ready
);
  typedef enum {H_PWR, H_IDLE, H_RD, H_WR, H_WRHI, H_RST, H_WAIT}
    frp_hst_type;
  frp_hst_type st_q, st_d;
  logic [15:0] cnt_q, cnt_d;
  logic ce_n_q, ce_n_d, oe_n_q, oe_n_d, we_n_q, we_n_d, rst_n_q, rst_n_d;
  logic [15:0] a_q, a_d, w_q, w_d, r_q, r_d;
  logic doe_q, doe_d, done_q, done_d;
  logic ready_q, ready_d;

  always_comb
  begin
    st_d = st_q;
    cnt_d = cnt_q;
    ce_n_d = ce_n_q;
    oe_n_d = oe_n_q;
    we_n_d = we_n_q;
    rst_n_d = rst_n_q;
    a_d = a_q;
    w_d = w_q;
    r_d = r_q;
    doe_d = doe_q;
    done_d = 1'b0;
    case (st_q)
      H_PWR:
      begin
        rst_n_d = 1'b1;
        st_d = H_WAIT;
        cnt_d = 16'(`FRP_RST_IDLE_CYC);
      end
      H_IDLE:
        if (do_reset)
        begin
          rst_n_d = 1'b0;
          st_d = H_RST;
          cnt_d = 16'h0004;
        end
        else if (req && cmd == CMD_READ)
        begin
          ce_n_d = 1'b0;
          oe_n_d = 1'b0;
          a_d = req_addr;
          st_d = H_RD;
          cnt_d = 16'(`FRP_CE_ACC_CYC + 1);
        end
        else if (req && (cmd == CMD_PROG || cmd == CMD_CFG))
        begin
          ce_n_d = 1'b0;
          we_n_d = 1'b0;
          a_d = (cmd == CMD_CFG) ? {4'hC, req_addr[11:0]} : req_addr;
          w_d = req_data;
          doe_d = 1'b1;
          st_d = H_WR;
        end
      H_RD:
        if (cnt_q == 16'h0000)
        begin
          r_d = bus.dq_dev;
          ce_n_d = 1'b1;
          oe_n_d = 1'b1;
          done_d = 1'b1;
          st_d = H_IDLE;
        end
        else
          cnt_d = cnt_q - 16'h0001;
      H_WR:
      begin
        we_n_d = 1'b1;
        st_d = H_WRHI;
      end
      H_WRHI:
      begin
        ce_n_d = 1'b1;
        doe_d = 1'b0;
        done_d = 1'b1;
        st_d = H_WAIT;
        cnt_d = 16'h0002;
      end
      H_RST:
        if (cnt_q == 16'h0000)
        begin
          rst_n_d = 1'b1;
          st_d = H_WAIT;
          cnt_d = 16'(`FRP_RST_WAIT_CYC);
        end
        else
          cnt_d = cnt_q - 16'h0001;
      H_WAIT:
        // Also waits for busy to clear, so reissue is safe
        // Reset is honoured here too, so it can cut a running program
        if (do_reset)
        begin
          rst_n_d = 1'b0;
          st_d = H_RST;
          cnt_d = 16'h0004;
        end
        else if (cnt_q == 16'h0000 && bus.ready_busy_n)
          st_d = H_IDLE;
        else if (cnt_q != 16'h0000)
          cnt_d = cnt_q - 16'h0001;
      default: st_d = H_IDLE;
    endcase
    ready_d = (st_d == H_IDLE);
  end

  always_ff @(posedge mclk)
  begin
    if (reset)
    begin
      st_q <= H_PWR;
      cnt_q <= 16'h0000;
      ce_n_q <= 1'b1;
      oe_n_q <= 1'b1;
      we_n_q <= 1'b1;
      rst_n_q <= 1'b0;
      a_q <= 16'h0000;
      w_q <= 16'h0000;
      r_q <= 16'h0000;
      doe_q <= 1'b0;
      done_q <= 1'b0;
      ready_q <= 1'b0;
    end
    else
    begin
      st_q <= st_d;
      cnt_q <= cnt_d;
      ce_n_q <= ce_n_d;
      oe_n_q <= oe_n_d;
      we_n_q <= we_n_d;
      rst_n_q <= rst_n_d;
      a_q <= a_d;
      w_q <= w_d;
      r_q <= r_d;
      doe_q <= doe_d;
      done_q <= done_d;
      ready_q <= ready_d;
    end
  end

  assign bus.ce_n = ce_n_q;
  assign bus.oe_n = oe_n_q;
  assign bus.we_n = we_n_q;
  assign bus.reset_n = rst_n_q;
  assign bus.burst_n = 1'b1;
  assign bus.addr = a_q;
  assign bus.dq_host = w_q;
  assign bus.dq_host_oe = doe_q;
  assign done = done_q;
  assign rd_data = r_q;
  assign ready = ready_q;
endmodule : frp_host

/* logic/frp_if.sv */
`timescale 1ns/100ps
interface frp_if;
  logic ce_n;
  logic oe_n;
  logic we_n;
  logic reset_n;
  logic burst_n;
  logic [15:0] addr;
  logic [15:0] dq_host;
  logic dq_host_oe;
  logic [15:0] dq_dev;
  logic dq_dev_oe;
  logic ready_busy_n;
  modport dev (input ce_n, oe_n, we_n, reset_n, burst_n, addr, dq_host,
    dq_host_oe, output dq_dev, dq_dev_oe, ready_busy_n);
  modport host (output ce_n, oe_n, we_n, reset_n, burst_n, addr, dq_host,
    dq_host_oe, input dq_dev, dq_dev_oe, ready_busy_n);
endinterface : frp_if

/* logic/frp_map.svh */
`ifndef FRP_MAP_SVH
`define FRP_MAP_SVH
`define FRP_CLK_PERIOD_NS 10
`define FRP_ACC_TIME_NS 90
`define FRP_SLEEP_EXTRA_NS 60
`define FRP_SLEEP_CYC ((`FRP_ACC_TIME_NS + `FRP_SLEEP_EXTRA_NS + \
  `FRP_CLK_PERIOD_NS - 1) / `FRP_CLK_PERIOD_NS)
`define FRP_CE_ACC_NS 90
`define FRP_CE_ACC_CYC ((`FRP_CE_ACC_NS + `FRP_CLK_PERIOD_NS - 1) / \
  `FRP_CLK_PERIOD_NS)
`define FRP_BURST_MIN_MHZ 5
`define FRP_BURST_GAP_CYC (1000 / (`FRP_BURST_MIN_MHZ * \
  `FRP_CLK_PERIOD_NS))
`define FRP_RST_IDLE_NS 500
`define FRP_RST_IDLE_CYC (`FRP_RST_IDLE_NS / `FRP_CLK_PERIOD_NS)
`define FRP_RST_BUSY_MIN_US 1
`define FRP_RST_BUSY_MAX_US 7
`define FRP_RST_BUSY_CYC ((`FRP_RST_BUSY_MAX_US * 1000) / \
  `FRP_CLK_PERIOD_NS)
`define FRP_RST_WAIT_US 11
`define FRP_RST_WAIT_CYC ((`FRP_RST_WAIT_US * 1000) / `FRP_CLK_PERIOD_NS)
`define FRP_OP_CYC 64
`define FRP_CFG_RESET 16'h0000
`define FRP_MARK_WORDS 4
`endif

/* logic/frp_pkg.sv */
package frp_pkg;
  typedef enum logic [1:0] {CMD_NONE, CMD_READ, CMD_PROG, CMD_CFG} frp_cmd_type;
  typedef enum {ST_READ, ST_BUSY, ST_RST_BUSY, ST_RST_IDLE} frp_state_type;
endpackage : frp_pkg

/* test/frp_chk.sv */
`timescale 1ns/100ps
module frp_chk (
  // Clock and reset
  input wire logic mclk,
  input wire logic reset,
  // Watched pins
  input wire logic ce_n,
  input wire logic oe_n,
  input wire logic reset_n,
  input wire logic dq_dev_oe,
  input wire logic ready_busy_n
);
  // --------------------------------------------------------------
  // Reset while busy: length of the busy tail
  // --------------------------------------------------------------
  // 1 us, 7 us (+10 cycles pipeline slack), 500 ns, program + reset
  localparam int RB_MIN = 100;
  localparam int RB_MAX = 710;
  localparam int IDLE_MAX = 50;
  localparam int OP_MAX = 780;
  logic rn_q;
  logic track_q;
  logic track_d;
  logic [11:0] cnt_q;
  logic [11:0] cnt_d;
  always_comb
  begin
    track_d = track_q;
    if (ready_busy_n)
      track_d = 1'b0;
    if (rn_q && !reset_n && !ready_busy_n)
      track_d = 1'b1;
    cnt_d = track_q ? cnt_q + 12'h001 : 12'h000;
  end
  always_ff @(posedge mclk)
  begin
    if (reset)
    begin
      rn_q <= 1'b1;
      track_q <= 1'b0;
      cnt_q <= 12'h000;
    end
    else
    begin
      rn_q <= reset_n;
      track_q <= track_d;
      cnt_q <= cnt_d;
    end
  end
  // --------------------------------------------------------------
  // Properties
  // --------------------------------------------------------------
  default clocking cb @(posedge mclk); endclocking
  default disable iff (reset);
  sequence s_busy_start;
    $fell(ready_busy_n) && reset_n;
  endsequence
  sequence s_busy_hold;
    !ready_busy_n [*8];
  endsequence
  property p_standby_float;
    ce_n [*2] |-> !dq_dev_oe;
  endproperty
  property p_oe_float;
    oe_n [*2] |-> !dq_dev_oe;
  endproperty
  property p_reset_float;
    !reset_n [*2] |-> !dq_dev_oe;
  endproperty
  property p_prog_hold;
    s_busy_start |-> s_busy_hold ##1 s_busy_hold;
  endproperty
  property p_busy_bound;
    s_busy_start |-> ##[1:OP_MAX] ready_busy_n;
  endproperty
  property p_reset_busy_low;
    rn_q && !reset_n && !ready_busy_n |=> s_busy_hold;
  endproperty
  property p_reset_busy_len;
    track_q && ready_busy_n |-> cnt_q >= RB_MIN && cnt_q <= RB_MAX;
  endproperty
  property p_idle_reset;
    $rose(reset_n) && !track_q |-> ##[0:IDLE_MAX] ready_busy_n;
  endproperty
  a_standby_float: assert property (p_standby_float)
    else $error("data driven while deselected");
  a_oe_float: assert property (p_oe_float)
    else $error("data driven with output enable high");
  a_reset_float: assert property (p_reset_float)
    else $error("data driven during reset pulse");
  a_prog_hold: assert property (p_prog_hold)
    else $error("program stopped early");
  a_busy_bound: assert property (p_busy_bound)
    else $error("busy never ends");
  a_reset_busy_low: assert property (p_reset_busy_low)
    else $error("busy dropped at reset");
  a_reset_busy_len: assert property (p_reset_busy_len)
    else $error("reset busy length out of range");
  a_idle_reset: assert property (p_idle_reset)
    else $error("idle reset too slow");
endmodule : frp_chk

/* test/tb_flash_reset_and_power_modes.sv */
`timescale 1ns/100ps
`include "frp_map.svh"
module tb_flash_reset_and_power_modes
  import frp_pkg::*;
;
  logic mclk = 1'b0;
  logic reset = 1'b1;
  logic req = 1'b0;
  frp_cmd_type cmd = CMD_NONE;
  logic [15:0] req_addr = 16'h0000;
  logic [15:0] req_data = 16'h0000;
  logic do_reset = 1'b0;
  logic done;
  logic ready;
  logic sleeping;
  logic corrupt_flag;
  logic [15:0] rd_data;
  logic [15:0] config_reg;
  int n_mismatch = 0;
  int n_compared = 0;
  logic saw_sleep = 1'b0;
  logic [15:0] mark_word;
  always #5 mclk = ~mclk;
  // Sticky record that automatic sleep was entered
  always @(posedge mclk)
  begin
    if (sleeping === 1'b1)
      saw_sleep <= 1'b1;
  end
  frp_if i_frp_if ();
  frp_device i_frp_device (.mclk(mclk), .reset(reset), .bus(i_frp_if),
    .sleeping(sleeping), .corrupt_flag(corrupt_flag),
    .config_reg(config_reg));
  frp_host i_frp_host (.mclk(mclk), .reset(reset), .bus(i_frp_if),
    .req(req), .cmd(cmd), .req_addr(req_addr), .req_data(req_data),
    .do_reset(do_reset), .done(done), .rd_data(rd_data), .ready(ready));
  frp_chk i_frp_chk (.mclk(mclk), .reset(reset), .ce_n(i_frp_if.ce_n),
    .oe_n(i_frp_if.oe_n), .reset_n(i_frp_if.reset_n),
    .dq_dev_oe(i_frp_if.dq_dev_oe), .ready_busy_n(i_frp_if.ready_busy_n));
  // --------------------------------------------------------------
  // Tasks
  // --------------------------------------------------------------
  task results;
    $display("compared %0d mismatched %0d", n_compared, n_mismatch);
    if (n_mismatch == 0 && n_compared > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask : results
  task check(input logic [15:0] seen, input logic [15:0] exp);
    n_compared++;
    if (seen !== exp)
    begin
      n_mismatch++;
      $display("mismatch t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check
  task wait_ready;
    int i;
    i = 0;
    while (ready !== 1'b1 && i < 3000)
    begin
      @(posedge mclk);
      i++;
    end
    check({15'h0000, ready}, 16'h0001);
  endtask : wait_ready
  task op(input frp_cmd_type c, input logic [15:0] a, input logic [15:0] d);
    int i;
    wait_ready();
    req <= 1'b1;
    cmd <= c;
    req_addr <= a;
    req_data <= d;
    @(posedge mclk);
    req <= 1'b0;
    i = 0;
    while (done !== 1'b1 && i < 100)
    begin
      @(posedge mclk);
      i++;
    end
    check({15'h0000, done}, 16'h0001);
  endtask : op
  // Held until taken, since the host only looks at it in H_IDLE and H_WAIT
  task hreset(input logic exp_busy);
    int i;
    logic bsy;
    i = 0;
    do_reset <= 1'b1;
    while (i_frp_if.reset_n !== 1'b0 && i < 2000)
    begin
      @(posedge mclk);
      i++;
    end
    bsy = (i_frp_if.reset_n === 1'b0) && (i_frp_if.ready_busy_n === 1'b0);
    do_reset <= 1'b0;
    check({15'h0000, i_frp_if.reset_n}, 16'h0000);
    check({15'h0000, bsy}, {15'h0000, exp_busy});
    wait_ready();
    check({15'h0000, corrupt_flag}, {15'h0000, exp_busy});
  endtask : hreset
  // --------------------------------------------------------------
  // Tests
  // --------------------------------------------------------------
  initial
  begin
    repeat (6) @(posedge mclk);
    reset <= 1'b0;
    op(CMD_PROG, 16'h0003, 16'h1234);
    op(CMD_PROG, 16'h0005, 16'hA5C3);
    op(CMD_READ, 16'h0003, 16'h0000);
    check(rd_data, 16'h1234);
    check({15'h0000, saw_sleep}, 16'h0000);
    repeat (2) @(posedge mclk);
    check({15'h0000, i_frp_if.dq_dev_oe}, 16'h0000);
    op(CMD_READ, 16'hFFF3, 16'h0000);
    mark_word = rd_data;
    op(CMD_PROG, 16'hFFF3, 16'h5A5A);
    op(CMD_READ, 16'hFFF3, 16'h0000);
    check({15'h0000, rd_data === 16'h5A5A}, 16'h0000);
    check(rd_data, mark_word);
    check({15'h0000, saw_sleep}, 16'h0001);
    op(CMD_CFG, 16'hC000, 16'h00FF);
    check(config_reg, 16'h00FF);
    hreset(1'b0);
    check(config_reg, `FRP_CFG_RESET);
    op(CMD_READ, 16'h0005, 16'h0000);
    check(rd_data, 16'hA5C3);
    op(CMD_PROG, 16'h0007, 16'h0F0F);
    hreset(1'b1);
    op(CMD_PROG, 16'h0007, 16'h0F0F);
    op(CMD_READ, 16'h0007, 16'h0000);
    check(rd_data, 16'h0F0F);
    results();
  end
  // Whole sequence needs about 2600 cycles
  initial
  begin
    repeat (20000) @(posedge mclk);
    n_mismatch++;
    results();
  end
endmodule : tb_flash_reset_and_power_modes
